/* File: hw/pas_top.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "pas_defs.svh"

module pas_top
    import pas_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // axi4-lite slave
    input wire logic [9:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [9:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // vertex stream side
    input wire logic I_START,
    input wire logic I_VTX_TAKEN,
    input wire logic I_CCW,
    output logic O_BUSY,
    output logic O_VTX_STEP,
    output logic O_LIST_DONE,
    output logic [5:0] O_REUSE,
    output logic O_INDEX_32,
    output logic O_INDEX_MODE,
    output logic O_CLIP_NEAR_TRI_POINT,
    output logic O_CLIP_W0,
    output logic [2:0] O_FIX_ENABLE,
    output logic O_DRAW_LAST_PIXEL,
    output logic [2:0] O_SHADING,
    output logic [2:0] O_EDGE_ENABLE,
    output logic O_CULLED,
    output logic O_USE_BACK_COLOUR,
    output logic [2:0] O_RENDER_KIND,
    output logic O_CFG_ERROR
);

    //--------------------------------------------------------------
    // decode helpers
    //--------------------------------------------------------------

    // map the 4-bit primitive type to a render kind
    function automatic pas_kind_t kind_of_type(input logic [3:0] t);
        case (t)
            4'h0: kind_of_type = PAS_KIND_POINT;
            4'h1: kind_of_type = PAS_KIND_LINE;
            4'h2: kind_of_type = PAS_KIND_TRI;
            4'h4: kind_of_type = PAS_KIND_RECT;
            4'h6: kind_of_type = PAS_KIND_TRI_WIRE;
            4'h7: kind_of_type = PAS_KIND_TRI_POINT;
            default: kind_of_type = PAS_KIND_NONE;
        endcase
    endfunction

    // map the clockwise 2-bit field to a render kind
    // code 01 is reserved and decodes to no kind
    function automatic pas_kind_t kind_of_cw(input logic [1:0] t);
        case (t)
            2'h0: kind_of_cw = PAS_KIND_TRI;
            2'h2: kind_of_cw = PAS_KIND_TRI_WIRE;
            2'h3: kind_of_cw = PAS_KIND_TRI_POINT;
            default: kind_of_cw = PAS_KIND_NONE;
        endcase
    endfunction

    // true for the triangle family of kinds
    function automatic logic is_tri(input pas_kind_t k);
        is_tri = (k == PAS_KIND_TRI) || (k == PAS_KIND_TRI_WIRE) ||
                 (k == PAS_KIND_TRI_POINT);
    endfunction

    // merge a write word under byte strobes and a writable mask
    // the top byte lane is ignored, registers are 24 bits wide
    function automatic logic [23:0] merge(input logic [23:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s,
                                          input logic [23:0] m);
        logic [23:0] be;
        be = {{8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & m;
        merge = (old & ~be) | (d[23:0] & be);
    endfunction

    //--------------------------------------------------------------
    // register bus
    //--------------------------------------------------------------

    pas_vcs_t vcs;
    pas_rpc_t rpc;
    logic [23:0] pvc;
    logic aw_held;
    logic w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    pas_state_t state;
    logic [23:0] remaining;
    logic odd_cycle;
    logic wr_fire;

    // a write completes once both halves are held and no answer waits
    assign wr_fire = aw_held && w_held && !O_BVALID;

    // write address and data are latched in either order
    // readies stay low while a response is still pending
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 10'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_held && !O_AWREADY && !wr_fire &&
                         !O_BVALID;
            O_WREADY <= !w_held && !O_WREADY && !wr_fire &&
                        !O_BVALID;
            if (I_AWVALID && O_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR;
                O_AWREADY <= 1'b0;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
                O_WREADY <= 1'b0;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response, unmapped addresses answer slverr
    // the response waits until both halves of the write are held
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_BVALID <= 1'b0;
            O_BRESP <= `PAS_RESP_OKAY;
        end else if (wr_fire) begin
            O_BVALID <= 1'b1;
            case (aw_addr)
                `PAS_ADDR_VCS, `PAS_ADDR_RPC, `PAS_ADDR_PVC,
                `PAS_ADDR_STAT: O_BRESP <= `PAS_RESP_OKAY;
                default: O_BRESP <= `PAS_RESP_SLVERR;
            endcase
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // setting registers, reserved bits never stored
    // reserved sub-addresses fall through without effect
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            vcs <= `PAS_VCS_RST;
            rpc <= `PAS_RPC_RST;
            pvc <= `PAS_PVC_RST;
        end else if (wr_fire) begin
            case (aw_addr)
                `PAS_ADDR_VCS: vcs <= merge(vcs, w_data, w_strb,
                                            `PAS_VCS_MASK);
                `PAS_ADDR_RPC: rpc <= merge(rpc, w_data, w_strb,
                                            `PAS_RPC_MASK);
                `PAS_ADDR_PVC: pvc <= merge(pvc, w_data, w_strb,
                                            24'hFFFFFF);
                default: ;
            endcase
        end
    end

    // read channel: settings are write-only, status is readable
    // any other address answers slverr with zero data
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= `PAS_RESP_OKAY;
        end else begin
            O_ARREADY <= !O_RVALID && !O_ARREADY;
            if (I_ARVALID && O_ARREADY) begin
                O_ARREADY <= 1'b0;
                O_RVALID <= 1'b1;
                if (I_ARADDR == `PAS_ADDR_STAT) begin
                    O_RDATA <= {5'h00, state, remaining};
                    O_RRESP <= `PAS_RESP_OKAY;
                end else begin
                    O_RDATA <= 32'h00000000;
                    O_RRESP <= `PAS_RESP_SLVERR;
                end
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------
    // vertex walk
    //--------------------------------------------------------------

    logic fast_mode;
    pas_reuse_t cur_reuse;
    pas_state_t next_state;

    assign fast_mode = vcs.render_mode[`PAS_MODE_FAST - 8];

    // pick this cycle's vertex sources
    // full and reserved modes fall back to all-new vertices
    always_comb begin
        if (vcs.render_mode[`PAS_MODE_RSVD - 8] &&
            !fast_mode) begin
            cur_reuse = 6'h00;
        end else if (!fast_mode) begin
            cur_reuse = 6'h00;
        end else if (odd_cycle) begin
            cur_reuse = vcs.render_mode[5:0];
        end else begin
            cur_reuse = vcs.even_cycle_vertex_reuse;
        end
    end

    // next state of the walk
    // a zero vertex count never leaves idle
    always_comb begin
        case (state)
            PAS_ST_IDLE: next_state = (I_START && pvc != 24'h000000) ?
                                      PAS_ST_RUN : PAS_ST_IDLE;
            PAS_ST_RUN: next_state = (I_VTX_TAKEN &&
                                      remaining == 24'h000001) ?
                                     PAS_ST_DONE : PAS_ST_RUN;
            PAS_ST_DONE: next_state = PAS_ST_IDLE;
            default: next_state = PAS_ST_IDLE;
        endcase
    end

    // state, vertex countdown and odd/even tracking
    // every start restarts on an odd cycle
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            state <= PAS_ST_IDLE;
            remaining <= 24'h000000;
            odd_cycle <= 1'b1;
        end else begin
            state <= next_state;
            if (state == PAS_ST_IDLE && I_START) begin
                remaining <= pvc;
                odd_cycle <= 1'b1;
            end else if (state == PAS_ST_RUN && I_VTX_TAKEN) begin
                remaining <= remaining - 24'h000001;
                odd_cycle <= !odd_cycle;
            end
        end
    end

    // walk outputs
    // busy and done follow the next state so they land with it
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_BUSY <= 1'b0;
            O_VTX_STEP <= 1'b0;
            O_LIST_DONE <= 1'b0;
            O_REUSE <= 6'h00;
        end else begin
            O_BUSY <= (next_state == PAS_ST_RUN);
            O_VTX_STEP <= (state == PAS_ST_RUN) && I_VTX_TAKEN;
            O_LIST_DONE <= (next_state == PAS_ST_DONE);
            O_REUSE <= cur_reuse;
        end
    end

    //--------------------------------------------------------------
    // raster control decode
    //--------------------------------------------------------------

    pas_kind_t kind;
    pas_kind_t base_kind;

    assign base_kind = kind_of_type(rpc.primitive_render_type);

    // two-sided selection applies only to triangle kinds
    // clockwise triangles then take the separate type field
    always_comb begin
        if (rpc.two_sided_render_type_enable && is_tri(base_kind) &&
            !I_CCW) begin
            kind = kind_of_cw(rpc.cw_render_type);
        end else begin
            kind = base_kind;
        end
    end

    // static controls
    // shading codes above gouraud fall back to solid
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_INDEX_32 <= 1'b0;
            O_INDEX_MODE <= 1'b0;
            O_CLIP_NEAR_TRI_POINT <= 1'b1;
            O_CLIP_W0 <= 1'b1;
            O_FIX_ENABLE <= 3'h7;
            O_DRAW_LAST_PIXEL <= 1'b0;
            O_SHADING <= PAS_SHADE_SOLID;
            O_EDGE_ENABLE <= 3'h0;
        end else begin
            O_INDEX_32 <= vcs.index_width_32;
            O_INDEX_MODE <= vcs.index_mode;
            O_CLIP_NEAR_TRI_POINT <= !rpc.tri_point_near_clip_dis;
            O_CLIP_W0 <= !rpc.w_clip_dis;
            O_FIX_ENABLE <= ~{rpc.fix_vout_compare_dis,
                              rpc.fix_temp_diff_dis,
                              rpc.fix_idle_dis};
            O_DRAW_LAST_PIXEL <= rpc.draw_last_pixel &&
                                 (kind == PAS_KIND_LINE);
            O_SHADING <= (rpc.shading > 3'h4) ? PAS_SHADE_SOLID :
                         rpc.shading;
            O_EDGE_ENABLE <= rpc.edge_flag;
        end
    end

    // winding dependent controls and error flag
    // the winding input is registered with the decoded kind
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_CULLED <= 1'b0;
            O_USE_BACK_COLOUR <= 1'b0;
            O_RENDER_KIND <= PAS_KIND_NONE;
            O_CFG_ERROR <= 1'b0;
        end else begin
            O_CULLED <= (I_CCW == rpc.cull_ccw);
            O_USE_BACK_COLOUR <= (I_CCW == rpc.back_face_colour_ccw);
            O_RENDER_KIND <= kind;
            O_CFG_ERROR <= (kind == PAS_KIND_NONE) ||
                           (vcs.render_mode[7:6] == 2'h2) ||
                           (!fast_mode &&
                            vcs.render_mode != 8'h00);
        end
    end

endmodule

/* File: hw/pas_defs.svh */
`ifndef PAS_DEFS_SVH
`define PAS_DEFS_SVH

// register byte addresses (sub-address index times four)
`define PAS_IDX_VCS 8'h20
`define PAS_IDX_RPC 8'h23
`define PAS_IDX_PVC 8'h24
`define PAS_IDX_STAT 8'h30
`define PAS_ADDR_VCS 10'h080
`define PAS_ADDR_RPC 10'h08C
`define PAS_ADDR_PVC 10'h090
`define PAS_ADDR_STAT 10'h0C0

// writable masks, reserved bits are dropped
`define PAS_VCS_MASK 24'h3FFF03
`define PAS_RPC_MASK 24'hF8FFFF

// reset values
`define PAS_VCS_RST 24'h000000
`define PAS_RPC_RST 24'h000000
`define PAS_PVC_RST 24'h000000

// field positions
`define PAS_MODE_FAST 14
`define PAS_MODE_RSVD 15

// bus responses
`define PAS_RESP_OKAY 2'h0
`define PAS_RESP_SLVERR 2'h2

`endif

/* File: hw/pas_pkg.sv */
package pas_pkg;

    // per-vertex source code
    typedef enum logic [1:0] {
        PAS_SRC_NEW = 2'h0,
        PAS_SRC_PREV_A = 2'h1,
        PAS_SRC_PREV_B = 2'h2,
        PAS_SRC_PREV_C = 2'h3
    } pas_src_t;

    // sources of the three vertices for one cycle
    typedef struct packed {
        pas_src_t a;
        pas_src_t b;
        pas_src_t c;
    } pas_reuse_t;

    // vertex cycle setting fields
    typedef struct packed {
        logic [1:0] rsvd_hi;
        pas_reuse_t even_cycle_vertex_reuse;
        logic [7:0] render_mode;
        logic [5:0] rsvd_lo;
        logic index_width_32;
        logic index_mode;
    } pas_vcs_t;

    // raster primitive control fields
    typedef struct packed {
        logic tri_point_near_clip_dis;
        logic w_clip_dis;
        logic fix_vout_compare_dis;
        logic fix_temp_diff_dis;
        logic fix_idle_dis;
        logic [2:0] rsvd;
        logic draw_last_pixel;
        logic [2:0] shading;
        logic [2:0] edge_flag;
        logic cull_ccw;
        logic back_face_colour_ccw;
        logic [1:0] cw_render_type;
        logic two_sided_render_type_enable;
        logic [3:0] primitive_render_type;
    } pas_rpc_t;

    // resolved render kind
    typedef enum logic [2:0] {
        PAS_KIND_POINT = 3'h0,
        PAS_KIND_LINE = 3'h1,
        PAS_KIND_TRI = 3'h2,
        PAS_KIND_RECT = 3'h3,
        PAS_KIND_TRI_WIRE = 3'h4,
        PAS_KIND_TRI_POINT = 3'h5,
        PAS_KIND_NONE = 3'h7
    } pas_kind_t;

    // shading selection
    typedef enum logic [2:0] {
        PAS_SHADE_SOLID = 3'h0,
        PAS_SHADE_FLAT_A = 3'h1,
        PAS_SHADE_FLAT_B = 3'h2,
        PAS_SHADE_FLAT_C = 3'h3,
        PAS_SHADE_GOURAUD = 3'h4
    } pas_shade_t;

    // vertex walk states
    typedef enum logic [2:0] {
        PAS_ST_IDLE = 3'b001,
        PAS_ST_RUN = 3'b010,
        PAS_ST_DONE = 3'b100
    } pas_state_t;

endpackage

/* File: verification/pas_top_assertions.sv */
`timescale 1ns/10ps
`include "pas_defs.svh"
// ----------
// bus, vertex walk and raster output checks
// ----------
module pas_chk
    import pas_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [9:0] I_ARADDR,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_START,
    input wire logic I_VTX_TAKEN,
    input wire logic O_BUSY,
    input wire logic O_VTX_STEP,
    input wire logic O_LIST_DONE,
    input wire logic O_DRAW_LAST_PIXEL,
    input wire logic [2:0] O_SHADING,
    input wire logic [2:0] O_RENDER_KIND
);
    // single clock domain, reset masks every check
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);

    // handshake steps
    sequence s_wr_take;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    sequence s_rd_take;
        I_ARVALID && O_ARREADY;
    endsequence
    sequence s_rd_refused;
        O_RVALID && O_RRESP == `PAS_RESP_SLVERR && O_RDATA == 32'h0;
    endsequence

    a_write_answer: assert property (s_wr_take |=> ##1 O_BVALID)
        else $error("write response missing");
    a_bresp_hold: assert property (O_BVALID && !I_BREADY |=>
        O_BVALID && $stable(O_BRESP)) else $error("write response dropped");
    a_ready_pending: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("ready while write pending");
    a_read_answer: assert property (s_rd_take |=> O_RVALID)
        else $error("read response missing");
    a_read_refused: assert property (s_rd_take ##0
        I_ARADDR != `PAS_ADDR_STAT |=> s_rd_refused)
        else $error("write-only read not refused");
    a_rdata_hold: assert property (O_RVALID && !I_RREADY |=>
        O_RVALID && $stable(O_RDATA)) else $error("read data dropped");
    a_busy_start: assert property ($rose(O_BUSY) |-> $past(I_START))
        else $error("busy without start");
    a_step_follow: assert property (O_BUSY && I_VTX_TAKEN |=> O_VTX_STEP)
        else $error("vertex step missing");
    a_done_idle: assert property (O_LIST_DONE |-> !O_BUSY ##1 !O_LIST_DONE)
        else $error("list done not a pulse");
    a_last_pixel: assert property (O_DRAW_LAST_PIXEL |->
        O_RENDER_KIND == PAS_KIND_LINE) else $error("last pixel off line");
    a_shade_legal: assert property (O_SHADING <= 3'h4)
        else $error("shading code illegal");
endmodule

bind pas_top pas_chk u_pas_chk (
    .I_MCLK, .I_RST_N, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
    .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY,
    .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .I_START, .I_VTX_TAKEN,
    .O_BUSY, .O_VTX_STEP, .O_LIST_DONE, .O_DRAW_LAST_PIXEL, .O_SHADING,
    .O_RENDER_KIND
);

/* File: verification/tb.sv */
`timescale 1ns/10ps
`include "pas_defs.svh"
module tb
    import pas_pkg::*;
;
    localparam logic [1:0] OK = `PAS_RESP_OKAY;
    localparam logic [1:0] ERR = `PAS_RESP_SLVERR;
    logic clk, rst_n, awv, wv, brdy, arv, rrdy, start, taken, ccw;
    logic [9:0] awa, ara;
    logic [31:0] wd, rdata;
    logic [3:0] ws;
    logic o_awr, o_wr, o_bv, o_arr, o_rv, busy, step, done, i32, imode;
    logic cnear, cw0, dlp, cull, back, cerr;
    logic [1:0] bresp, rresp;
    logic [5:0] reuse;
    logic [2:0] fix, shd, edg, kind;
    logic [23:0] w;
    int failures = 0;
    int compares = 0;
    int i;
    // raster control words, winding per entry, expected render kind
    logic [23:0] rw [13] = '{24'h800000, 24'h409801, 24'h282502,
        24'h003284, 24'h00C006, 24'h000007, 24'h000052, 24'h000072,
        24'h000076, 24'h000032, 24'h077003, 24'h00000F, 24'h000062};
    logic [12:0] rc = 13'h0116;
    logic [2:0] rk [13] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h4,
        3'h5, 3'h4, 3'h7, 3'h7, 3'h7, 3'h2};

    pas_top u_pas_top (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(o_awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
        .O_WREADY(o_wr), .O_BRESP(bresp), .O_BVALID(o_bv), .I_BREADY(brdy),
        .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(o_arr), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(o_rv), .I_RREADY(rrdy), .I_START(start),
        .I_VTX_TAKEN(taken), .I_CCW(ccw), .O_BUSY(busy), .O_VTX_STEP(step),
        .O_LIST_DONE(done), .O_REUSE(reuse), .O_INDEX_32(i32),
        .O_INDEX_MODE(imode), .O_CLIP_NEAR_TRI_POINT(cnear), .O_CLIP_W0(cw0),
        .O_FIX_ENABLE(fix), .O_DRAW_LAST_PIXEL(dlp), .O_SHADING(shd),
        .O_EDGE_ENABLE(edg), .O_CULLED(cull), .O_USE_BACK_COLOUR(back),
        .O_RENDER_KIND(kind), .O_CFG_ERROR(cerr)
    );

    // ----------
    // helpers
    // ----------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bus write: address and data together, bready up until response
    task automatic wr(input logic [9:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (o_awr)
                awv <= 1'b0;
            if (o_wr)
                wv <= 1'b0;
            if (o_bv) begin
                got = 1'b1;
                brdy <= 1'b0;
                chk(bresp, r);
            end
        end
    endtask

    // bus read, rready held until data arrives
    task automatic rd(input logic [9:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            if (o_arr)
                arv <= 1'b0;
        end while (!o_rv);
        rrdy <= 1'b0;
        chk(rdata, d);
        chk(rresp, r);
    endtask

    // start pulse, then one consumed vertex
    task automatic go;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
    endtask

    task automatic vtx;
        @(posedge clk);
        taken <= 1'b1;
        @(posedge clk);
        taken <= 1'b0;
        @(posedge clk);
        chk(step, 1'h1);
    endtask

    // bounded wait for the end of the list
    task automatic fin;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 4) begin
            @(posedge clk);
            n++;
        end
        chk(done, 1'h1);
        chk(busy, 1'h0);
    endtask

    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #3000000;
        failures++;
        stop_test;
    end

    // ----------
    // tests
    // ----------
    initial begin
        rst_n = 1'b0;
        {awv, wv, brdy, arv, rrdy, start, taken, ccw} = 8'h00;
        awa = 10'h000;
        ara = 10'h000;
        wd = 32'h0;
        ws = 4'hF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        chk(fix, 3'h7);
        chk(cnear, 1'h1);
        chk(cw0, 1'h1);
        chk(kind, PAS_KIND_POINT);
        rd(`PAS_ADDR_STAT, 32'h01000000, OK);
        $display("reset test done");
        for (i = 0; i < 13; i++) begin
            w = rw[i];
            ccw <= rc[i];
            wr(`PAS_ADDR_RPC, {8'hFF, w}, OK);
            tick(3);
            chk(cnear, !w[23]);
            chk(cw0, !w[22]);
            chk(fix, 3'(~w[21:19]));
            chk(dlp, w[15] && rk[i] == 3'h1);
            chk(shd, w[14:12] > 3'h4 ? 3'h0 : w[14:12]);
            chk(edg, w[11:9]);
            chk(cull, rc[i] == w[8]);
            chk(back, rc[i] == w[7]);
            chk(kind, rk[i]);
            chk(cerr, rk[i] == 3'h7);
        end
        $display("raster control test done");
        ccw <= 1'b0;
        wr(`PAS_ADDR_VCS, 32'h00215B03, OK);
        wr(`PAS_ADDR_PVC, 32'h00000003, OK);
        tick(3);
        chk(i32, 1'h1);
        chk(imode, 1'h1);
        chk(cerr, 1'h0);
        go;
        chk(busy, 1'h1);
        tick(1);
        chk(reuse, 6'h1B);
        vtx;
        tick(2);
        chk(reuse, 6'h21);
        rd(`PAS_ADDR_STAT, 32'h02000002, OK);
        vtx;
        tick(2);
        chk(reuse, 6'h1B);
        chk(busy, 1'h1);
        vtx;
        fin;
        $display("fast cycle test done");
        wr(`PAS_ADDR_VCS, 32'h00210000, OK);
        wr(`PAS_ADDR_PVC, 32'h00000001, OK);
        tick(3);
        chk(i32, 1'h0);
        chk(imode, 1'h0);
        go;
        tick(1);
        chk(reuse, 6'h00);
        vtx;
        fin;
        wr(`PAS_ADDR_VCS, 32'h00008000, OK);
        wr(`PAS_ADDR_PVC, 32'h00000000, OK);
        tick(3);
        chk(cerr, 1'h1);
        go;
        chk(busy, 1'h0);
        $display("full cycle test done");
        wr(10'h088, 32'hFFFFFFFF, ERR);
        wr(10'h3FC, 32'hFFFFFFFF, ERR);
        wr(`PAS_ADDR_STAT, 32'hFFFFFFFF, OK);
        rd(`PAS_ADDR_RPC, 32'h0, ERR);
        tick(3);
        chk(fix, 3'h7);
        chk(kind, PAS_KIND_TRI);
        $display("refusal test done");
        stop_test;
    end
endmodule
